// ===== design/addr_resolve_if.sv
// Bundle between the operand-address resolver and its user
`timescale 1ns/1ps
interface addr_resolve_if;
	logic [7:0]                    file_addr;   // Address field of opcode
	logic                          access_bit;  // 0 = access bank, 1 = banked
	logic [3:0]                    bank_sel;    // Bank select register value
	logic [ptr_ops_pkg::PTR_W-1:0] frame_ptr;   // Frame pointer value
	logic                          ext_en;      // Extension enabled
	logic [ptr_ops_pkg::PTR_W-1:0] eff_addr;    // Resolved address
	logic                          indexed;     // Frame-relative form used

	modport requester (output file_addr, access_bit, bank_sel, frame_ptr, ext_en,
		input eff_addr, indexed);
	modport resolver (input file_addr, access_bit, bank_sel, frame_ptr, ext_en,
		output eff_addr, indexed);
endinterface

// ===== design/indexed_offset_pointer_ops.sv
// Extended pointer-arithmetic instructions and indexed operand addressing
`timescale 1ns/1ps
module indexed_offset_pointer_ops (
	input  wire logic                          ref_clk_i,          // 20 MHz reference clock
	input  wire logic                          sys_rst_i,          // Async reset, active high
	input  wire logic                          ext_enable_i,       // Extension configuration bit
	input  wire logic                          instr_valid_i,      // Instruction word present at Q1
	input  wire logic [ptr_ops_pkg::OPC_W-1:0] instr_i,            // Instruction word
	input  wire logic [7:0]                    file_addr_i,        // Operand address field
	input  wire logic                          access_bit_i,       // Access bit of opcode
	input  wire logic                          dest_bit_i,         // Destination select of opcode
	input  wire logic [3:0]                    bank_sel_reg_i,     // Bank select register
	input  wire logic                          ptr_wr_en_i,        // Core writes a pointer
	input  wire logic [1:0]                    ptr_wr_sel_i,       // Which pointer the core writes
	input  wire logic [ptr_ops_pkg::PTR_W-1:0] ptr_wr_data_i,      // Value the core writes
	input  wire logic [ptr_ops_pkg::IP_W-1:0]  return_stack_top_i, // Top of return stack
	output logic [1:0]                         q_phase_o,          // Quarter counter, registered one clock late
	output logic [ptr_ops_pkg::PTR_W-1:0]      ptr0_o,             // File select pointer 0
	output logic [ptr_ops_pkg::PTR_W-1:0]      ptr1_o,             // File select pointer 1
	output logic [ptr_ops_pkg::PTR_W-1:0]      frame_pointer_o,    // File select pointer 2
	output logic [ptr_ops_pkg::PTR_W-1:0]      eff_addr_o,         // Resolved operand address
	output logic                               indexed_o,          // Address was frame-relative
	output logic                               dest_to_file_o,     // 1 = result to file register
	output logic                               ip_load_o,          // Load instruction pointer pulse
	output logic [ptr_ops_pkg::IP_W-1:0]       ip_load_value_o,    // New instruction pointer
	output logic                               stack_pop_o,        // Pop return stack pulse
	output logic                               mem_wr_o,           // Data memory write pulse
	output logic [ptr_ops_pkg::PTR_W-1:0]      mem_wr_addr_o,      // Data memory write address
	output logic [7:0]                         mem_wr_data_o,      // Data memory write data
	output logic                               ext_instr_o,        // Extended instruction decoded
	output logic                               flush_o             // Idle second cycle in progress
);
	////////////////////////////////////////////////////////////////////////////
	// Declarations
	logic [1:0]                          q_r;                          // Quarter counter
	logic                                ext_en_r;                     // Registered extension bit
	logic [ptr_ops_pkg::OPC_W-1:0]       opc_r;                        // Opcode latched at Q1
	logic                                opc_valid_r;                  // Latched opcode is live
	ptr_ops_pkg::exec_state_t            state_r;                      // Run or forced idle
	logic [ptr_ops_pkg::PTR_W-1:0]       ptr_r [ptr_ops_pkg::NPTR];    // Pointer file
	logic [ptr_ops_pkg::PTR_W-1:0]       sub_nxt;                      // Pointer minus literal
	logic [ptr_ops_pkg::PTR_W-1:0]       sel_ptr;                      // Pointer chosen by opcode
	logic [1:0]                          sel_idx;                      // Index of chosen pointer
	logic                                is_sub;                       // Pointer subtract decoded
	logic                                is_sub_ret;                   // Subtract-and-return decoded
	logic                                is_push;                      // Push literal decoded
	logic                                at_q4;                        // Write-back quarter strobe
	addr_resolve_if                      ar ();                        // Resolver bundle

	////////////////////////////////////////////////////////////////////////////
	// Quarter-cycle divider: a slow enable from the reference clock
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			q_r <= ptr_ops_pkg::Q1;
		end else begin
			q_r <= q_r + 2'h1;
		end
	end

	assign at_q4 = (q_r == ptr_ops_pkg::Q4);

	////////////////////////////////////////////////////////////////////////////
	// Configuration bit sampled each clock; defaults to off through reset
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			ext_en_r <= 1'b0;
		end else begin
			ext_en_r <= ext_enable_i;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Opcode latch at Q1; a flush cycle refuses the fetched word
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			opc_r       <= 16'h0000;
			opc_valid_r <= 1'b0;
		end else if (q_r == ptr_ops_pkg::Q1) begin
			// Fetched word is discarded while the new pointer takes effect
			opc_r       <= instr_i;
			opc_valid_r <= instr_valid_i && (state_r == ptr_ops_pkg::ST_RUN);
		end else if (at_q4) begin
			opc_valid_r <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Decode; extended forms exist only with the extension on
	always_comb begin
		is_sub     = opc_valid_r && ext_en_r &&
			(opc_r[ptr_ops_pkg::OPC_HI_MSB:ptr_ops_pkg::OPC_HI_LSB] == ptr_ops_pkg::OPC_SUB_PTR);
		is_sub_ret = is_sub &&
			(opc_r[ptr_ops_pkg::SEL_MSB:ptr_ops_pkg::SEL_LSB] == ptr_ops_pkg::SEL_RETURN);
		is_push    = opc_valid_r && ext_en_r &&
			(opc_r[ptr_ops_pkg::OPC_HI_MSB:ptr_ops_pkg::OPC_HI_LSB] == ptr_ops_pkg::OPC_PUSH_LIT);
		// Return variant always works on the frame pointer
		sel_idx = is_sub_ret ? ptr_ops_pkg::SEL_FRAME
			: opc_r[ptr_ops_pkg::SEL_MSB:ptr_ops_pkg::SEL_LSB];
		sel_ptr = ptr_r[sel_idx];
	end

	// Full-width subtract so borrow reaches the high byte
	assign sub_nxt = sel_ptr - {6'h00, opc_r[ptr_ops_pkg::LIT6_MSB:0]};

	////////////////////////////////////////////////////////////////////////////
	// Pointer file: instruction write-back has priority over the core port
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			for (int i = 0; i < ptr_ops_pkg::NPTR; i++) begin
				ptr_r[i] <= ptr_ops_pkg::PTR_RESET;
			end
		end else if (at_q4 && is_sub) begin
			// No status flags are produced by this path
			ptr_r[sel_idx] <= sub_nxt;
		end else if (at_q4 && is_push) begin
			// Decrement wraps within the data space
			ptr_r[ptr_ops_pkg::SEL_FRAME] <= ptr_r[ptr_ops_pkg::SEL_FRAME] - 12'h001;
		end else if (ptr_wr_en_i && (ptr_wr_sel_i != ptr_ops_pkg::SEL_RETURN)) begin
			ptr_r[ptr_wr_sel_i] <= ptr_wr_data_i;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Two-cycle return: run, then one whole idle instruction cycle
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			state_r <= ptr_ops_pkg::ST_RUN;
		end else begin
			case (state_r)
				ptr_ops_pkg::ST_RUN: begin
					if (at_q4 && is_sub_ret) begin
						state_r <= ptr_ops_pkg::ST_FLUSH;
					end
				end
				ptr_ops_pkg::ST_FLUSH: begin
					// All four quarters pass with no operation
					if (at_q4) begin
						state_r <= ptr_ops_pkg::ST_RUN;
					end
				end
				default: begin
					state_r <= ptr_ops_pkg::ST_RUN;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Return: instruction pointer taken from the return stack top
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			ip_load_o       <= 1'b0;
			stack_pop_o     <= 1'b0;
			ip_load_value_o <= ptr_ops_pkg::IP_RESET;
		end else begin
			ip_load_o   <= at_q4 && is_sub_ret;
			stack_pop_o <= at_q4 && is_sub_ret;
			if (at_q4 && is_sub_ret) begin
				ip_load_value_o <= return_stack_top_i;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Push literal: write at the frame pointer before it moves
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			mem_wr_o      <= 1'b0;
			mem_wr_addr_o <= ptr_ops_pkg::PTR_RESET;
			mem_wr_data_o <= 8'h00;
		end else begin
			mem_wr_o <= at_q4 && is_push;
			if (at_q4 && is_push) begin
				mem_wr_addr_o <= ptr_r[ptr_ops_pkg::SEL_FRAME];
				mem_wr_data_o <= opc_r[ptr_ops_pkg::LIT8_MSB:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Operand address resolution for every byte and bit instruction
	assign ar.file_addr  = file_addr_i;
	assign ar.access_bit = access_bit_i;
	assign ar.bank_sel   = bank_sel_reg_i;
	assign ar.frame_ptr  = ptr_r[ptr_ops_pkg::SEL_FRAME];
	assign ar.ext_en     = ext_en_r;

	operand_addr_resolver u_resolver (
		.ar (ar.resolver)
	);

	// Registered every clock, independent of opcode class
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			eff_addr_o     <= ptr_ops_pkg::PTR_RESET;
			indexed_o      <= 1'b0;
			dest_to_file_o <= 1'b0;
		end else begin
			eff_addr_o     <= ar.eff_addr;
			indexed_o      <= ar.indexed;
			dest_to_file_o <= dest_bit_i;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Status outputs, all from flops
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			q_phase_o       <= ptr_ops_pkg::Q1;
			ptr0_o          <= ptr_ops_pkg::PTR_RESET;
			ptr1_o          <= ptr_ops_pkg::PTR_RESET;
			frame_pointer_o <= ptr_ops_pkg::PTR_RESET;
			ext_instr_o     <= 1'b0;
			flush_o         <= 1'b0;
		end else begin
			q_phase_o       <= q_r;
			ptr0_o          <= ptr_r[0];
			ptr1_o          <= ptr_r[1];
			frame_pointer_o <= ptr_r[ptr_ops_pkg::SEL_FRAME];
			ext_instr_o     <= is_sub || is_push;
			flush_o         <= (state_r == ptr_ops_pkg::ST_FLUSH);
		end
	end
endmodule

// ===== design/operand_addr_resolver.sv
// Combinational operand address resolver for byte and bit instructions
`timescale 1ns/1ps
module operand_addr_resolver (
	addr_resolve_if.resolver ar
);
	////////////////////////////////////////////////////////////////////////////
	// Resolve direct, banked or frame-relative address
	always_comb begin
		ar.indexed = 1'b0;
		if (ar.access_bit) begin
			// Banked location, same with or without extension
			ar.eff_addr = {ar.bank_sel, ar.file_addr};
		end else if (ar.ext_en && (ar.file_addr <= ptr_ops_pkg::INDEX_LIMIT)) begin
			// Offset added to frame pointer; wraps in data space
			ar.indexed  = 1'b1;
			ar.eff_addr = ar.frame_ptr + {4'h0, ar.file_addr};
		end else if (ar.file_addr <= ptr_ops_pkg::INDEX_LIMIT) begin
			// Low part of access bank
			ar.eff_addr = {ptr_ops_pkg::ACCESS_LOW_BANK, ar.file_addr};
		end else begin
			// High part of access bank keeps direct meaning
			ar.eff_addr = {ptr_ops_pkg::ACCESS_HIGH_BANK, ar.file_addr};
		end
	end
endmodule

// ===== design/ptr_ops_pkg.sv
// Shared constants for the pointer-arithmetic and indexed-address block
package ptr_ops_pkg;
	// Widths
	localparam int PTR_W  = 12;                        // Data address space width
	localparam int IP_W   = 21;                        // Instruction pointer width
	localparam int OPC_W  = 16;                        // Instruction word width
	localparam int LIT6_W = 6;                         // Subtract literal width
	localparam int NPTR   = 3;                         // Number of file select pointers

	// Opcode field positions
	localparam int OPC_HI_MSB  = 15;                   // Upper byte of opcode
	localparam int OPC_HI_LSB  = 8;
	localparam int SEL_MSB     = 7;                    // Pointer select field
	localparam int SEL_LSB     = 6;
	localparam int LIT6_MSB    = 5;                    // 6-bit literal field
	localparam int LIT8_MSB    = 7;                    // 8-bit literal field

	// Opcode encodings
	localparam logic [7:0] OPC_SUB_PTR   = 8'he9;      // Pointer subtract family
	localparam logic [7:0] OPC_PUSH_LIT  = 8'hfa;      // Push literal
	localparam logic [1:0] SEL_RETURN    = 2'h3;       // Subtract-and-return variant
	localparam logic [1:0] SEL_FRAME     = 2'h2;       // Frame pointer index

	// Address resolution
	localparam logic [7:0] INDEX_LIMIT   = 8'h5f;      // Highest offset taken as indexed
	localparam logic [3:0] ACCESS_LOW_BANK  = 4'h0;    // Low half of access bank
	localparam logic [3:0] ACCESS_HIGH_BANK = 4'hf;    // High half of access bank

	// Reset values
	localparam logic [PTR_W-1:0] PTR_RESET = 12'h000;  // Pointer contents after reset
	localparam logic [IP_W-1:0]  IP_RESET  = 21'h000000;

	// Quarter-cycle timing: one instruction cycle is four reference clocks
	localparam int          CLK_PERIOD_NS = 50;        // Reference clock period
	localparam int          INSTR_CYCLE_NS = 200;      // Instruction cycle period
	localparam int          Q_COUNT = INSTR_CYCLE_NS / CLK_PERIOD_NS;
	localparam logic [1:0]  Q1 = 2'h0;                 // Decode quarter
	localparam logic [1:0]  Q4 = 2'(Q_COUNT - 1);      // Write-back quarter

	// Execution states
	typedef enum logic [0:0] {
		ST_RUN,                                        // Normal instruction cycle
		ST_FLUSH                                       // Forced no-operation cycle
	} exec_state_t;
endpackage

// ===== test/indexed_offset_pointer_ops_bench.sv
// Self-checking bench for the pointer-arithmetic and indexed-address block
`timescale 1ns/1ps
module indexed_offset_pointer_ops_bench;
	logic        ref_clk_i = 1'b0;      // 20 MHz clock
	logic        sys_rst_i = 1'b1;      // Held for four cycles
	logic        ext_en    = 1'b0;      // Extension bit, off by default
	logic        iv        = 1'b0;      // Instruction present
	logic [15:0] instr     = 16'h0000;  // Instruction word
	logic [7:0]  fa        = 8'h00;     // Operand address field
	logic        acc       = 1'b0;      // Access bit
	logic        dest      = 1'b0;      // Destination bit
	logic [3:0]  bank      = 4'h0;      // Bank select
	logic        wr_en     = 1'b0;      // Core pointer write
	logic [1:0]  wr_sel    = 2'h0;      // Pointer chosen
	logic [11:0] wr_data   = 12'h000;   // Value written
	logic [20:0] return_stack_top       = 21'h012345; // Return stack top
	logic [1:0]  qp;                    // Quarter counter copy
	logic [11:0] p0, p1, fp, ea, mwa;   // Pointers, address, write address
	logic        ix, dfile, ipl, pop, mw, fl, xi; // Flags and pulses
	logic [20:0] ipv;                   // New instruction pointer
	logic [7:0]  mwd;                   // Write data
	int          checks     = 0;        // Comparisons made
	int          fail_count = 0;        // Mismatches seen

	indexed_offset_pointer_ops indexed_offset_pointer_ops_i (
		.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .ext_enable_i(ext_en), .instr_valid_i(iv),
		.instr_i(instr), .file_addr_i(fa), .access_bit_i(acc), .dest_bit_i(dest), .bank_sel_reg_i(bank),
		.ptr_wr_en_i(wr_en), .ptr_wr_sel_i(wr_sel), .ptr_wr_data_i(wr_data), .return_stack_top_i(return_stack_top),
		.q_phase_o(qp), .ptr0_o(p0), .ptr1_o(p1), .frame_pointer_o(fp), .eff_addr_o(ea), .indexed_o(ix),
		.dest_to_file_o(dfile), .ip_load_o(ipl), .ip_load_value_o(ipv), .stack_pop_o(pop), .mem_wr_o(mw),
		.mem_wr_addr_o(mwa), .mem_wr_data_o(mwd), .ext_instr_o(xi), .flush_o(fl)
	);

	// Free-running clock
	always #25 ref_clk_i = ~ref_clk_i;

	////////////////////////////////////////////////////////////////////////////////
	// Shared helpers
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		checks++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD %0t %s got %0h exp %0h", $time, msg, got, exp);
		end
	endtask

	task automatic conclude;
		$display("Counts: %0d checks, %0d mismatches", checks, fail_count);
		if (fail_count == 0 && checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk_i);
	endtask

	// Core write of one pointer; copy visible one edge after the write edge
	task automatic set_ptr(input logic [1:0] sel, input logic [11:0] val);
		@(posedge ref_clk_i);
		wr_en   <= 1'b1;
		wr_sel  <= sel;
		wr_data <= val;
		@(posedge ref_clk_i);
		wr_en <= 1'b0;
		@(posedge ref_clk_i);
	endtask

	// Present a word for the cycle before a decode edge; returns at the decode edge
	task automatic issue(input logic [15:0] word);
		int n;
		n = 0;
		do begin
			@(negedge ref_clk_i);
			n++;
		end while (qp !== 2'h2 && n < 16);
		if (n >= 16) begin
			fail_count++;
			$display("BAD %0t quarter counter stuck", $time);
			conclude();
		end
		@(posedge ref_clk_i);
		iv    <= 1'b1;
		instr <= word;
		@(posedge ref_clk_i);
		iv <= 1'b0;
	endtask

	// Drive operand fields, flip destination bit, judge the registered answer
	task automatic addr(input logic a, input logic [7:0] f, input logic [11:0] exp, input logic exp_ix);
		@(posedge ref_clk_i);
		acc  <= a;
		fa   <= f;
		bank <= 4'h5;
		dest <= ~dest;
		@(posedge ref_clk_i);
		@(negedge ref_clk_i);
		chk(ea, exp, "address");
		chk(ix, exp_ix, "indexed flag");
		chk(dfile, dest, "destination");
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Scenarios
	task automatic t_direct;
		set_ptr(2'h2, 12'h100);
		addr(1'b0, 8'h20, 12'h020, 1'b0);
		addr(1'b0, 8'h80, 12'hf80, 1'b0);
		addr(1'b1, 8'h33, 12'h533, 1'b0);
		issue(16'he985);
		tick(2);
		@(negedge ref_clk_i);
		chk(xi, 1'b0, "no extended decode with extension off");
		tick(2);
		@(negedge ref_clk_i);
		chk(fp, 12'h100, "subtract with extension off");
		$display("Test direct done, %0d mismatches", fail_count);
	endtask

	task automatic t_indexed;
		@(posedge ref_clk_i);
		ext_en <= 1'b1;
		set_ptr(2'h2, 12'ha00);
		addr(1'b0, 8'h2c, 12'ha2c, 1'b1);
		addr(1'b0, 8'h5f, 12'ha5f, 1'b1);
		addr(1'b0, 8'h60, 12'hf60, 1'b0);
		addr(1'b1, 8'h10, 12'h510, 1'b0);
		set_ptr(2'h2, 12'hfe0);
		addr(1'b0, 8'h5f, 12'h03f, 1'b1);
		set_ptr(2'h2, 12'h000);
		addr(1'b0, 8'h2c, 12'h02c, 1'b1);
		$display("Test indexed done, %0d mismatches", fail_count);
	endtask

	// Back-to-back subtracts on all three pointers, with borrow and wrap
	task automatic t_subtract;
		set_ptr(2'h0, 12'h100);
		set_ptr(2'h1, 12'h010);
		set_ptr(2'h2, 12'h3ff);
		issue(16'he93f);
		issue(16'he97f);
		issue(16'he9a3);
		tick(3);
		// Return pulse would stand only in the clock after the write-back quarter
		@(negedge ref_clk_i);
		chk(ipl, 1'b0, "no return on plain subtract");
		@(negedge ref_clk_i);
		chk(p0, 12'h0c1, "ptr0 borrow");
		chk(p1, 12'hfd1, "ptr1 wrap");
		chk(fp, 12'h3dc, "frame subtract");
		$display("Test subtract done, %0d mismatches", fail_count);
	endtask

	// Subtract-and-return, with a word offered during the idle cycle
	task automatic t_return;
		set_ptr(2'h1, 12'h050);
		set_ptr(2'h2, 12'h3ff);
		issue(16'he9e3);
		tick(3);
		iv    <= 1'b1;
		instr <= 16'he941;
		// Pulses stand in the clock right after the write-back quarter
		@(negedge ref_clk_i);
		chk(ipl, 1'b1, "load pulse");
		chk(pop, 1'b1, "pop pulse");
		chk(ipv, 21'h012345, "load value");
		tick(1);
		iv <= 1'b0;
		@(negedge ref_clk_i);
		chk(fl, 1'b1, "idle cycle");
		chk(fp, 12'h3dc, "frame after return");
		chk(ipl, 1'b0, "load pulse ended");
		tick(6);
		@(negedge ref_clk_i);
		chk(p1, 12'h050, "word in idle cycle dropped");
		issue(16'he941);
		tick(4);
		@(negedge ref_clk_i);
		chk(p1, 12'h04f, "word after idle cycle");
		$display("Test return done, %0d mismatches", fail_count);
	endtask

	task automatic t_push;
		set_ptr(2'h2, 12'h1ec);
		issue(16'hfa08);
		tick(3);
		// Write pulse stands one clock, with the quarter copy at write-back
		@(negedge ref_clk_i);
		chk(mw, 1'b1, "push write");
		chk(mwa, 12'h1ec, "push address");
		chk(mwd, 8'h08, "push data");
		chk(xi, 1'b1, "push decoded as extended");
		chk(qp, 2'h3, "write-back quarter");
		@(negedge ref_clk_i);
		chk(mw, 1'b0, "push write ended");
		chk(fp, 12'h1eb, "push decrement");
		$display("Test push done, %0d mismatches", fail_count);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		tick(4);
		sys_rst_i <= 1'b0;
		t_direct();
		t_indexed();
		t_subtract();
		t_return();
		t_push();
		conclude();
	end

	// Hang guard, far beyond the expected run
	initial begin
		#2000000;
		fail_count++;
		$display("BAD %0t run limit reached", $time);
		conclude();
	end
endmodule

// ===== test/indexed_offset_pointer_ops_properties.sv
// Concurrent checks on the ports of the pointer-arithmetic and indexed-address block
`timescale 1ns/1ps
module indexed_offset_pointer_ops_properties (
	input wire logic                                ref_clk_i,       // Reference clock
	input wire logic                                sys_rst_i,       // Async reset, active high
	input wire logic                                ext_enable_i,    // Extension configuration bit
	input wire logic [7:0]                          file_addr_i,     // Operand address field
	input wire logic                                access_bit_i,    // Access bit
	input wire logic                                dest_bit_i,      // Destination select
	input wire logic [3:0]                          bank_sel_reg_i,  // Bank select register
	input wire logic [ptr_ops_pkg::PTR_W-1:0]       frame_pointer_o, // Frame pointer copy
	input wire logic [ptr_ops_pkg::PTR_W-1:0]       eff_addr_o,      // Resolved address
	input wire logic                                indexed_o,       // Frame-relative flag
	input wire logic                                dest_to_file_o,  // Destination output
	input wire logic                                ip_load_o,       // Pointer load pulse
	input wire logic                                stack_pop_o,     // Stack pop pulse
	input wire logic                                mem_wr_o,        // Memory write pulse
	input wire logic [ptr_ops_pkg::PTR_W-1:0]       mem_wr_addr_o,   // Memory write address
	input wire logic                                flush_o          // Idle second cycle
);
	// One clock domain, so one default clock and reset
	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (sys_rst_i);

	////////////////////////////////////////////////////////////////////////////////
	// Return sequencing: pop and load travel together and open the idle cycle
	property p_pop_with_load;
		(ip_load_o || stack_pop_o) |-> ip_load_o && stack_pop_o && !flush_o ##1 flush_o;
	endproperty
	a_pop_with_load: assert property (p_pop_with_load) else $error("return pulses not paired");

	// Pulses last one clock only
	property p_load_pulse;
		ip_load_o |=> !ip_load_o && !stack_pop_o;
	endproperty
	a_load_pulse: assert property (p_load_pulse) else $error("return pulse too long");

	// Idle cycle is bounded, so a stuck flush shows up
	property p_flush_end;
		$rose(flush_o) |-> ##[1:4] !flush_o;
	endproperty
	a_flush_end: assert property (p_flush_end) else $error("idle cycle does not end");

	// No data memory write happens while the second cycle idles
	property p_idle_flush;
		flush_o |-> !mem_wr_o;
	endproperty
	a_idle_flush: assert property (p_idle_flush) else $error("write during idle cycle");

	////////////////////////////////////////////////////////////////////////////////
	// Push writes at the old frame address and leaves the pointer one lower
	property p_push_dec;
		mem_wr_o |-> frame_pointer_o == mem_wr_addr_o ##1 frame_pointer_o == 12'(mem_wr_addr_o - 12'h001);
	endproperty
	a_push_dec: assert property (p_push_dec) else $error("push decrement wrong");

	////////////////////////////////////////////////////////////////////////////////
	// Extension off at one edge means no frame-relative answer two edges later
	property p_ext_off;
		!sys_rst_i && !ext_enable_i |=> ##1 !indexed_o;
	endproperty
	a_ext_off: assert property (p_ext_off) else $error("indexed with extension off");

	// Banked form always takes the bank select register
	property p_banked;
		!sys_rst_i && access_bit_i |=> eff_addr_o == {$past(bank_sel_reg_i), $past(file_addr_i)} && !indexed_o;
	endproperty
	a_banked: assert property (p_banked) else $error("banked address wrong");

	// Access-bank fields above the index limit stay direct, in the high half
	property p_direct_high;
		!sys_rst_i && !access_bit_i && file_addr_i > 8'h5f |=> eff_addr_o == {4'hf, $past(file_addr_i)} && !indexed_o;
	endproperty
	a_direct_high: assert property (p_direct_high) else $error("high access address wrong");

	// Frame-relative answer is frame plus offset, offset within limit
	property p_indexed_sum;
		indexed_o |-> eff_addr_o == 12'(frame_pointer_o + $past(file_addr_i)) && $past(file_addr_i) <= 8'h5f;
	endproperty
	a_indexed_sum: assert property (p_indexed_sum) else $error("indexed address wrong");

	// Destination bit passes unchanged through one flop
	property p_dest;
		!$past(sys_rst_i) |-> dest_to_file_o == $past(dest_bit_i);
	endproperty
	a_dest: assert property (p_dest) else $error("destination bit altered");
endmodule

bind indexed_offset_pointer_ops indexed_offset_pointer_ops_properties indexed_offset_pointer_ops_properties_i (
	.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .ext_enable_i(ext_enable_i), .file_addr_i(file_addr_i),
	.access_bit_i(access_bit_i), .dest_bit_i(dest_bit_i), .bank_sel_reg_i(bank_sel_reg_i),
	.frame_pointer_o(frame_pointer_o), .eff_addr_o(eff_addr_o), .indexed_o(indexed_o),
	.dest_to_file_o(dest_to_file_o), .ip_load_o(ip_load_o), .stack_pop_o(stack_pop_o),
	.mem_wr_o(mem_wr_o), .mem_wr_addr_o(mem_wr_addr_o), .flush_o(flush_o)
);
